/* logic/cep_pkg.sv */
package cep_pkg;

  // widest codeword (l2 data buffer granule plus its check bits)
  localparam int CW_W = 80;
  localparam int SYN_W = 7;
  localparam int IDX_W = 16;
  localparam int PAR_W = 1;

  // protection granules, in data bits
  localparam int G_I_TAG = 34;
  localparam int G_I_DATA = 32;
  localparam int G_TLB_TAG = 40;
  localparam int G_TLB_DATA = 47;
  localparam int G_D_TAG = 35;
  localparam int G_D_DATA = 32;
  localparam int G_D_DIRTY = 2;
  localparam int G_L2_TAG_64K = 32;
  localparam int G_L2_TAG_128K = 31;
  localparam int G_L2_TAG_256K = 30;
  localparam int G_L2_DATA = 64;
  localparam int G_L2_BUF = 72;

  // hamming check bits plus one overall parity bit
  function automatic int cep_ecc_cw(input int w);
    int k;
    k = 1;
    for (int j = 1; j <= SYN_W; j++) begin
      if ((1 << k) < w + k + 1) begin
        k = k + 1;
      end
    end
    return w + k + 1;
  endfunction : cep_ecc_cw

  typedef enum logic [3:0] {
    RAM_I_TAG, RAM_I_DATA, RAM_TLB_TAG, RAM_TLB_DATA, RAM_D_TAG,
    RAM_D_DATA, RAM_D_DIRTY, RAM_L2_TAG, RAM_L2_DATA, RAM_L2_BUF
  } cep_ram_t;

  typedef enum logic [1:0] {L2_64K, L2_128K, L2_256K} cep_l2sz_t;

  typedef enum logic [2:0] {
    FIX_NONE, FIX_INV_SET, FIX_INV_ENTRY, FIX_CLEAN_INV,
    FIX_CLEAN_INV_DUP, FIX_REWRITE, FIX_INVALIDATE
  } cep_fix_t;

  typedef enum logic {ST_IDLE, ST_FIX} cep_state_t;

endpackage : cep_pkg

/* logic/cep_ram_protect.sv */
`timescale 1ns/1ps
module cep_ram_protect
  import cep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire cep_pkg::cep_l2sz_t l2_size,
  input wire logic chk_valid,
  output logic chk_ready,
  input wire cep_pkg::cep_ram_t chk_ram,
  input wire logic [cep_pkg::IDX_W-1:0] chk_index,
  input wire logic [cep_pkg::CW_W-1:0] chk_word,
  output logic stall,
  output logic fix_valid,
  input wire logic fix_ready,
  output cep_pkg::cep_fix_t fix_cmd,
  output cep_pkg::cep_ram_t fix_ram,
  output logic [cep_pkg::IDX_W-1:0] fix_index,
  output logic [cep_pkg::CW_W-1:0] fix_word,
  output logic fix_poison,
  output logic resp_valid,
  output logic resp_retry,
  output logic resp_poison,
  output logic [cep_pkg::CW_W-1:0] resp_word,
  output logic refetch_req,
  output logic walk_req,
  output logic evt_valid,
  output cep_pkg::cep_ram_t evt_ram,
  output logic evt_uncorr,
  output logic loss_irq
);
  import cep_pkg::*;

  // codeword length of each granule; l2 tag shrinks as the cache grows
  function automatic int cep_width(input cep_ram_t r, input cep_l2sz_t s);
    int w;
    w = 0;
    case (r)
      RAM_I_TAG: w = G_I_TAG + PAR_W;
      RAM_I_DATA: w = G_I_DATA + PAR_W;
      RAM_TLB_TAG: w = G_TLB_TAG + PAR_W;
      RAM_TLB_DATA: w = G_TLB_DATA + PAR_W;
      RAM_D_TAG: w = cep_ecc_cw(G_D_TAG);
      RAM_D_DATA: w = cep_ecc_cw(G_D_DATA);
      RAM_D_DIRTY: w = cep_ecc_cw(G_D_DIRTY);
      RAM_L2_TAG: begin
        case (s)
          L2_128K: w = cep_ecc_cw(G_L2_TAG_128K);
          L2_256K: w = cep_ecc_cw(G_L2_TAG_256K);
          default: w = cep_ecc_cw(G_L2_TAG_64K);
        endcase
      end
      RAM_L2_DATA: w = cep_ecc_cw(G_L2_DATA);
      RAM_L2_BUF: w = cep_ecc_cw(G_L2_BUF);
      default: w = 0;
    endcase
    return w;
  endfunction : cep_width

  // xor of the positions of all set bits
  function automatic logic [SYN_W-1:0] cep_syn(input logic [CW_W-1:0] cw);
    logic [SYN_W-1:0] s;
    s = '0;
    for (int i = 1; i < CW_W; i++) begin
      if (cw[i]) begin
        s = s ^ SYN_W'(i);
      end
    end
    return s;
  endfunction : cep_syn

  cep_state_t state_q;
  logic take;
  logic is_ecc;
  int wid;
  logic [CW_W-1:0] cw;
  logic [CW_W-1:0] corr;
  logic [SYN_W-1:0] syn;
  logic par;
  logic err;
  logic unc;
  cep_fix_t act;
  logic do_retry;
  logic do_refetch;
  logic do_walk;
  logic do_poison;
  logic do_irq;

  logic chk_ready_q;
  logic stall_q;
  logic fix_valid_q;
  cep_fix_t fix_cmd_q;
  cep_ram_t fix_ram_q;
  logic [IDX_W-1:0] fix_index_q;
  logic [CW_W-1:0] fix_word_q;
  logic fix_poison_q;
  logic resp_valid_q;
  logic resp_retry_q;
  logic resp_poison_q;
  logic [CW_W-1:0] resp_word_q;
  logic refetch_q;
  logic walk_q;
  logic refetch_pend_q;
  logic walk_pend_q;
  logic evt_valid_q;
  cep_ram_t evt_ram_q;
  logic evt_uncorr_q;
  logic irq_q;

  assign take = chk_valid && chk_ready_q;

  // check the granule; bits beyond its codeword are masked off
  always_comb begin
    wid = cep_width(chk_ram, l2_size);
    for (int i = 0; i < CW_W; i++) begin
      cw[i] = chk_word[i] && (i < wid);
    end
    is_ecc = (chk_ram == RAM_D_TAG) || (chk_ram == RAM_D_DATA) ||
             (chk_ram == RAM_D_DIRTY) || (chk_ram == RAM_L2_TAG) ||
             (chk_ram == RAM_L2_DATA) || (chk_ram == RAM_L2_BUF);
    syn = cep_syn(cw);
    par = ^cw;
    corr = cw;
    unc = 1'b0;
    if (!is_ecc) begin
      // a parity pair cancels out, so doubles pass silently
      err = par;
    end else begin
      err = par || (syn != '0);
      if (!par && (syn != '0)) begin
        unc = 1'b1;
      end else if (par && (int'(syn) >= wid)) begin
        unc = 1'b1; // points outside the granule: several bits hit
      end else if (par) begin
        corr[syn] = ~cw[syn];
      end
    end
  end

  // recovery action per ram and outcome
  always_comb begin
    act = FIX_NONE;
    do_retry = 1'b1;
    do_refetch = 1'b0;
    do_walk = 1'b0;
    do_poison = 1'b0;
    do_irq = 1'b0;
    case (chk_ram)
      RAM_I_TAG, RAM_I_DATA: begin
        act = FIX_INV_SET;
        do_refetch = 1'b1;
      end
      RAM_TLB_TAG, RAM_TLB_DATA: begin
        act = FIX_INV_ENTRY;
        do_walk = 1'b1;
      end
      RAM_D_TAG: begin
        act = unc ? FIX_INVALIDATE : FIX_CLEAN_INV_DUP;
        do_refetch = 1'b1;
        do_irq = unc;
      end
      RAM_D_DATA: begin
        act = FIX_CLEAN_INV;
        do_refetch = 1'b1;
        do_poison = unc;
      end
      RAM_D_DIRTY: begin
        act = unc ? FIX_INVALIDATE : FIX_CLEAN_INV;
        do_refetch = 1'b1;
        do_irq = unc;
      end
      RAM_L2_TAG: begin
        // the retry of a dropped tag misses and refetches below
        act = unc ? FIX_INVALIDATE : FIX_REWRITE;
        do_irq = unc;
      end
      RAM_L2_DATA, RAM_L2_BUF: begin
        act = FIX_REWRITE;
        do_retry = 1'b0;
        do_poison = unc;
      end
      default: begin
        act = FIX_NONE;
      end
    endcase
  end

  // sequencing: idle passes clean words, fix holds the access
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      chk_ready_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          chk_ready_q <= 1'b1;
          if (take && err) begin
            state_q <= ST_FIX;
            chk_ready_q <= 1'b0; // one granule at a time
            stall_q <= 1'b1;
          end
        end
        ST_FIX: begin
          if (fix_ready) begin
            state_q <= ST_IDLE;
            chk_ready_q <= 1'b1;
            stall_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // repair command; the corrected word goes back into the ram
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fix_valid_q <= 1'b0;
      fix_cmd_q <= FIX_NONE;
      fix_ram_q <= RAM_I_TAG;
      fix_index_q <= '0;
      fix_word_q <= '0;
      fix_poison_q <= 1'b0;
    end else if (state_q == ST_IDLE && take && err) begin
      fix_valid_q <= 1'b1;
      fix_cmd_q <= act;
      fix_ram_q <= chk_ram;
      fix_index_q <= chk_index;
      fix_word_q <= corr;
      fix_poison_q <= do_poison;
    end else if (fix_valid_q && fix_ready) begin
      fix_valid_q <= 1'b0;
    end
  end

  // answer to the access: at once when clean, after repair otherwise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      resp_valid_q <= 1'b0;
      resp_retry_q <= 1'b0;
      resp_poison_q <= 1'b0;
      resp_word_q <= '0;
      refetch_pend_q <= 1'b0;
      walk_pend_q <= 1'b0;
    end else begin
      resp_valid_q <= 1'b0;
      if (state_q == ST_IDLE && take) begin
        resp_word_q <= corr;
        resp_retry_q <= err && do_retry;
        resp_poison_q <= err && do_poison;
        refetch_pend_q <= err && do_refetch;
        walk_pend_q <= err && do_walk;
        resp_valid_q <= !err;
      end else if (state_q == ST_FIX && fix_ready) begin
        resp_valid_q <= 1'b1;
      end
    end
  end

  // refill from below once the entry is gone
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refetch_q <= 1'b0;
      walk_q <= 1'b0;
    end else begin
      refetch_q <= state_q == ST_FIX && fix_ready && refetch_pend_q;
      walk_q <= state_q == ST_FIX && fix_ready && walk_pend_q;
    end
  end

  // error event and data-loss interrupt, pulsed on detection
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_valid_q <= 1'b0;
      evt_ram_q <= RAM_I_TAG;
      evt_uncorr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      evt_valid_q <= state_q == ST_IDLE && take && err;
      irq_q <= state_q == ST_IDLE && take && err && do_irq;
      if (state_q == ST_IDLE && take && err) begin
        evt_ram_q <= chk_ram;
        evt_uncorr_q <= unc;
      end
    end
  end

  assign chk_ready = chk_ready_q;
  assign stall = stall_q;
  assign fix_valid = fix_valid_q;
  assign fix_cmd = fix_cmd_q;
  assign fix_ram = fix_ram_q;
  assign fix_index = fix_index_q;
  assign fix_word = fix_word_q;
  assign fix_poison = fix_poison_q;
  assign resp_valid = resp_valid_q;
  assign resp_retry = resp_retry_q;
  assign resp_poison = resp_poison_q;
  assign resp_word = resp_word_q;
  assign refetch_req = refetch_q;
  assign walk_req = walk_q;
  assign evt_valid = evt_valid_q;
  assign evt_ram = evt_ram_q;
  assign evt_uncorr = evt_uncorr_q;
  assign loss_irq = irq_q;

endmodule : cep_ram_protect

/* verif/cep_fix_model.sv */
`timescale 1ns/1ps
module cep_fix_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fix_valid,
  input wire logic slow,
  output logic fix_ready
);
  logic [1:0] age_q;
  // age of the pending repair; a slow ram port keeps it waiting
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      age_q <= 2'h0;
    end else begin
      age_q <= (fix_valid && !fix_ready) ? age_q + 2'h1 : 2'h0;
    end
  end
  // the ram port takes the write back or invalidate
  assign fix_ready = fix_valid && (!slow || age_q == 2'h3);
endmodule : cep_fix_model

/* verif/cep_ram_protect_asserts.sv */
`timescale 1ns/1ps
module cep_ram_protect_asserts
  import cep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic chk_valid,
  input wire logic chk_ready,
  input wire logic stall,
  input wire logic fix_valid,
  input wire logic fix_ready,
  input wire cep_pkg::cep_fix_t fix_cmd,
  input wire cep_pkg::cep_ram_t fix_ram,
  input wire logic fix_poison,
  input wire logic resp_valid,
  input wire logic resp_retry,
  input wire logic refetch_req,
  input wire logic walk_req,
  input wire logic evt_valid,
  input wire logic evt_uncorr,
  input wire logic loss_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // repair handshake, and the same step for the icache and l2 data families
  sequence s_fix_done;
    fix_valid && fix_ready;
  endsequence
  sequence s_fix_i;
    s_fix_done ##0 fix_ram inside {RAM_I_TAG, RAM_I_DATA};
  endsequence
  sequence s_fix_l2d;
    s_fix_done ##0 fix_ram inside {RAM_L2_DATA, RAM_L2_BUF};
  endsequence
  a_err_stall: assert property (evt_valid |-> stall && fix_valid)
    else $error("error event without stall");
  a_stall_hold: assert property (stall && !fix_ready |=> stall)
    else $error("stall dropped before repair");
  a_resume: assert property (s_fix_done |=> resp_valid && !stall && chk_ready)
    else $error("no answer after repair");
  a_one_answer: assert property (chk_valid && chk_ready |=> resp_valid != evt_valid)
    else $error("taken check gave no single outcome");
  a_refused: assert property (stall |-> !chk_ready)
    else $error("request accepted while stalled");
  a_icache_refetch: assert property (s_fix_i |=> refetch_req && resp_retry)
    else $error("icache error not refetched");
  a_inv_set: assert property (fix_valid && fix_ram inside {RAM_I_TAG, RAM_I_DATA}
    |-> fix_cmd == FIX_INV_SET)
    else $error("icache repair not a set invalidate");
  a_l2d_inline: assert property (s_fix_l2d |=> !resp_retry && !refetch_req)
    else $error("l2 data not corrected inline");
  a_walk_tlb: assert property (walk_req |->
    resp_retry && $past(fix_ram) inside {RAM_TLB_TAG, RAM_TLB_DATA})
    else $error("walk without tlb repair");
  // the pulse and the command are launched on the same edge
  a_loss_unc: assert property (loss_irq |-> evt_uncorr && fix_cmd == FIX_INVALIDATE)
    else $error("loss interrupt without invalidate");
  a_poison_unc: assert property (fix_valid && fix_poison |-> evt_uncorr)
    else $error("poison on a correctable error");
  a_evt_pulse: assert property (evt_valid |=> !evt_valid)
    else $error("error event longer than a cycle");
endmodule : cep_ram_protect_asserts

bind cep_ram_protect cep_ram_protect_asserts u_chk (
  .sys_clk(sys_clk),
  .rstn(rstn),
  .chk_valid(chk_valid),
  .chk_ready(chk_ready),
  .stall(stall),
  .fix_valid(fix_valid),
  .fix_ready(fix_ready),
  .fix_cmd(fix_cmd),
  .fix_ram(fix_ram),
  .fix_poison(fix_poison),
  .resp_valid(resp_valid),
  .resp_retry(resp_retry),
  .refetch_req(refetch_req),
  .walk_req(walk_req),
  .evt_valid(evt_valid),
  .evt_uncorr(evt_uncorr),
  .loss_irq(loss_irq)
);

/* verif/test_cache_ram_error_protection.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, ac); end end
module test_cache_ram_error_protection;
  import cep_pkg::*;
  // fl is uncorrectable, retry, poison; sd is refetch, walk, irq
  typedef struct {
    cep_ram_t ram; cep_l2sz_t sz; logic [CW_W-1:0] w; cep_fix_t cmd; logic [2:0] fl, sd;
  } cep_row_t;
  logic sys_clk, rstn, chk_valid, chk_ready, stall, fix_valid, fix_ready, fix_poison;
  logic resp_valid, resp_retry, resp_poison, refetch_req, walk_req, evt_valid;
  logic evt_uncorr, loss_irq, slow;
  cep_l2sz_t l2_size;
  cep_ram_t chk_ram, fix_ram, evt_ram;
  cep_fix_t fix_cmd;
  logic [IDX_W-1:0] chk_index, fix_index;
  logic [CW_W-1:0] chk_word, fix_word, resp_word;
  int err_count = 0, check_count = 0, cyc = 0;
  cep_row_t rows [13] = '{
    '{RAM_I_DATA, L2_64K, 80'h2, FIX_INV_SET, 3'h2, 3'h4},
    '{RAM_I_TAG, L2_64K, 80'h6, FIX_NONE, 3'h0, 3'h0},
    '{RAM_TLB_DATA, L2_64K, 80'h20, FIX_INV_ENTRY, 3'h2, 3'h2},
    '{RAM_D_TAG, L2_64K, 80'h8, FIX_CLEAN_INV_DUP, 3'h2, 3'h4},
    '{RAM_D_DATA, L2_64K, 80'h28, FIX_CLEAN_INV, 3'h7, 3'h4},
    '{RAM_D_DIRTY, L2_64K, 80'h1, FIX_CLEAN_INV, 3'h2, 3'h4},
    '{RAM_D_DIRTY, L2_64K, 80'h6, FIX_INVALIDATE, 3'h6, 3'h5},
    '{RAM_L2_TAG, L2_128K, 80'h8, FIX_REWRITE, 3'h2, 3'h0},
    '{RAM_L2_TAG, L2_64K, 80'h60_0000_0000, FIX_INVALIDATE, 3'h6, 3'h1},
    '{RAM_L2_TAG, L2_256K, 80'h60_0000_0000, FIX_NONE, 3'h0, 3'h0},
    '{RAM_L2_DATA, L2_64K, 80'h8, FIX_REWRITE, 3'h0, 3'h0},
    '{RAM_L2_BUF, L2_64K, 80'h28, FIX_REWRITE, 3'h5, 3'h0},
    '{RAM_L2_DATA, L2_64K, 80'hF, FIX_NONE, 3'h0, 3'h0}};

  cep_ram_protect DUT (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .l2_size(l2_size),
    .chk_valid(chk_valid),
    .chk_ready(chk_ready),
    .chk_ram(chk_ram),
    .chk_index(chk_index),
    .chk_word(chk_word),
    .stall(stall),
    .fix_valid(fix_valid),
    .fix_ready(fix_ready),
    .fix_cmd(fix_cmd),
    .fix_ram(fix_ram),
    .fix_index(fix_index),
    .fix_word(fix_word),
    .fix_poison(fix_poison),
    .resp_valid(resp_valid),
    .resp_retry(resp_retry),
    .resp_poison(resp_poison),
    .resp_word(resp_word),
    .refetch_req(refetch_req),
    .walk_req(walk_req),
    .evt_valid(evt_valid),
    .evt_ram(evt_ram),
    .evt_uncorr(evt_uncorr),
    .loss_irq(loss_irq)
  );
  cep_fix_model u_far (.sys_clk(sys_clk), .rstn(rstn), .fix_valid(fix_valid), .slow(slow),
    .fix_ready(fix_ready));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // hang guard, far above the 130 or so cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // one check request, then follow it to its answer
  task automatic run_row(input int i);
    cep_row_t r;
    int n;
    logic [2:0] sd;
    logic [CW_W-1:0] ew;
    r = rows[i];
    n = 0;
    // clean words come back masked to their granule
    ew = (r.cmd == FIX_NONE && r.sz != L2_256K) ? r.w : 80'h0;
    @(posedge sys_clk);
    chk_valid <= 1'b1;
    chk_ram <= r.ram;
    chk_word <= r.w;
    chk_index <= 16'(i);
    l2_size <= r.sz;
    // ready looked at settled, before the edge that takes the request
    do begin
      @(negedge sys_clk);
      n++;
    end while (chk_ready !== 1'b1 && n < 50);
    `CHK("take", 1'b1, chk_ready)
    @(posedge sys_clk);
    chk_valid <= 1'b0;
    @(negedge sys_clk);
    sd = {refetch_req, walk_req, loss_irq};
    `CHK("evt", r.cmd != FIX_NONE, evt_valid)
    if (evt_valid === 1'b1) begin
      `CHK("stall", 1'b1, stall)
      `CHK("cmd", r.cmd, fix_cmd)
      `CHK("fixram", r.ram, fix_ram)
      `CHK("ram", r.ram, evt_ram)
      `CHK("idx", 16'(i), fix_index)
      `CHK("unc", r.fl[2], evt_uncorr)
      `CHK("fixpoi", r.fl[0], fix_poison)
      if (r.cmd == FIX_REWRITE && !r.fl[2]) `CHK("fixw", 80'h0, fix_word)
      do begin
        @(negedge sys_clk);
        sd |= {refetch_req, walk_req, loss_irq};
        n++;
      end while (resp_valid !== 1'b1 && n < 50);
    end
    `CHK("resp", 1'b1, resp_valid)
    `CHK("rty", r.fl[1], resp_retry)
    `CHK("poi", r.fl[0], resp_poison)
    `CHK("side", r.sd, sd)
    if (r.fl[1:0] == 2'h0) `CHK("word", ew, resp_word)
    $display("row %0d done", i);
  endtask : run_row

  initial begin
    rstn = 1'b0;
    chk_valid = 1'b0;
    chk_ram = RAM_I_TAG;
    chk_index = 16'h0;
    chk_word = 80'h0;
    l2_size = L2_64K;
    slow = 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("rst_ready", 1'b0, chk_ready)
    @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("ready", 1'b1, chk_ready)
    $display("reset test done");
    // table once with a prompt ram port, once with a slow one
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      slow <= p[0];
      for (int i = 0; i < 13; i++) run_row(i);
    end
    // reset lands while a repair is still pending
    @(posedge sys_clk);
    slow <= 1'b1;
    chk_valid <= 1'b1;
    chk_ram <= RAM_L2_DATA;
    chk_word <= 80'h8;
    @(posedge sys_clk);
    chk_valid <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(negedge sys_clk);
    `CHK("rst_stall", 1'b0, stall)
    `CHK("rst_fix", 1'b0, fix_valid)
    @(posedge sys_clk);
    rstn <= 1'b1;
    slow <= 1'b0;
    run_row(10);
    $display("mid repair reset test done");
    finish_test();
  end
endmodule : test_cache_ram_error_protection
